// ---- verilog/clkpwr_map.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  clock and power mode control block.
  Assumes a 20 MHz reference clock and APB byte addressing.
*/
`ifndef CLKPWR_MAP_SVH
`define CLKPWR_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define CTRL_OFFSET      12'h000
`define STAT_OFFSET      12'h004

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define CTRL_CLK_SEL_BIT   0
`define CTRL_FOSC_EN_BIT   1
`define CTRL_REG_LVL_BIT   2
`define CTRL_BOOST_BIT     3
`define CTRL_OSC_LV_BIT    4
`define CTRL_CONV_LV_BIT   5
`define CTRL_SVD_EN_BIT    6
`define CTRL_WIDTH         7
`define CTRL_RESET         7'h00

////////////////////////////////////////////////////////////////////////////////
// Status register fields
`define STAT_SRC_FAST_BIT  0
`define STAT_REG_LVL_BIT   1
`define STAT_BOOST_OK_BIT  2
`define STAT_REG_OK_BIT    3
`define STAT_FOSC_OK_BIT   4
`define STAT_RC_SLOW_BIT   5
`define STAT_FOSC_USE_BIT  6

////////////////////////////////////////////////////////////////////////////////
// Timing
`define REF_CLK_MHZ        20
`define BOOST_SETTLE_US    100000
`define REG_SETTLE_US      2500
`define FOSC_SETTLE_US     5000
`define BOOST_SETTLE_CYC   (`BOOST_SETTLE_US * `REF_CLK_MHZ)
`define REG_SETTLE_CYC     (`REG_SETTLE_US * `REF_CLK_MHZ)
`define FOSC_SETTLE_CYC    (`FOSC_SETTLE_US * `REF_CLK_MHZ)
`define TIMER_WIDTH        21
`define STRAP_WAIT         2'h3

`endif

// ---- verilog/clkpwr_pkg.sv ----
/*
  Types of the clock and power mode control block.
  Assumes clkpwr_map.svh for widths.
*/
`include "clkpwr_map.svh"

package clkpwr_pkg;

  typedef struct packed {
    logic supply_detector_enable;
    logic converter_lowvolt_select;
    logic osc_lowvolt_select;
    logic booster_enable;
    logic osc_regulator_level;
    logic fast_osc_enable;
    logic cpu_clock_select;
  } ctrl_s;

  typedef logic [`TIMER_WIDTH-1:0] tmr_t;

endpackage : clkpwr_pkg

// ---- verilog/glitch_free_clk_sel.sv ----
/*
  Glitch-free selector between the slow and fast oscillator levels.
  Assumes both levels are already synchronised to ref_clk_in.
*/
`timescale 1ns/100ps
`default_nettype none

module glitch_free_clk_sel
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  // Sources and select
  input  wire logic slow_lvl_in,
  input  wire logic fast_lvl_in,
  input  wire logic sel_fast_in,
  // Outputs
  output logic      cpu_clk_out,
  output logic      src_fast_out
);

  logic en_slow_r;
  logic en_slow_nxt;
  logic en_fast_r;
  logic en_fast_nxt;
  logic clk_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Each gate opens or closes only while its source is low, and never
  // both at once, so no output pulse is ever cut short
  always_comb
  begin
    en_slow_nxt = en_slow_r;
    en_fast_nxt = en_fast_r;
    if (!slow_lvl_in)
    begin
      en_slow_nxt = !sel_fast_in && !en_fast_r;
    end
    if (!fast_lvl_in)
    begin
      en_fast_nxt = sel_fast_in && !en_slow_r;
    end
    clk_nxt = (en_slow_r && slow_lvl_in) || (en_fast_r && fast_lvl_in);
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      en_slow_r   <= 1'b1;
      en_fast_r   <= 1'b0;
      cpu_clk_out <= 1'b0;
    end
    else
    begin
      en_slow_r   <= en_slow_nxt;
      en_fast_r   <= en_fast_nxt;
      cpu_clk_out <= clk_nxt;
    end
  end

  assign src_fast_out = en_fast_r;

endmodule : glitch_free_clk_sel

`default_nettype wire

// ---- verilog/clock_power_mode_control.sv ----
/*
  Clock source, oscillator, regulator, booster, low-voltage mode and supply
  detector control, reached over APB.
  Assumes oscillator levels and mask-option straps arrive asynchronously on
  pins; software keeps the documented sequences and uses the settle flags.
*/
`timescale 1ns/100ps
`default_nettype none
`include "clkpwr_map.svh"

// What this block does
// - After reset the CPU runs from the slow oscillator.
// - After reset the fast oscillator is stopped.
// - After reset the regulator level selects the low 1.3 V setting.
// - After reset booster and both low-voltage selects are off.
// - After reset the supply detector is off.
// - RC slow oscillator with fast oscillator used fixes level at 2.1 V.
// - RC slow oscillator without fast oscillator runs at 1.3 V.
module clock_power_mode_control
  import clkpwr_pkg::*;
#(
  parameter int unsigned BOOST_CYC = `BOOST_SETTLE_CYC,
  parameter int unsigned REG_CYC   = `REG_SETTLE_CYC,
  parameter int unsigned FOSC_CYC  = `FOSC_SETTLE_CYC
)
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Oscillator pins and mask-option straps
  input  wire logic        slow_osc_in,
  input  wire logic        fast_osc_in,
  input  wire logic        rc_slow_strap_in,
  input  wire logic        fast_used_strap_in,
  // Analog controls
  output logic             cpu_clk_out,
  output logic             fast_osc_enable_out,
  output logic             osc_regulator_level_out,
  output logic             booster_enable_out,
  output logic             osc_lowvolt_select_out,
  output logic             converter_lowvolt_select_out,
  output logic             supply_detector_enable_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] meta_r;
  logic [3:0] sync_r;

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
    end
    else
    begin
      meta_r <= {fast_used_strap_in, rc_slow_strap_in, fast_osc_in, slow_osc_in};
      sync_r <= meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture, once the synchronisers have filled after release
  logic [1:0] cap_cnt_r;
  logic [1:0] cap_cnt_nxt;
  logic       rc_slow_r;
  logic       rc_slow_nxt;
  logic       fast_used_r;
  logic       fast_used_nxt;

  always_comb
  begin
    cap_cnt_nxt   = cap_cnt_r;
    rc_slow_nxt   = rc_slow_r;
    fast_used_nxt = fast_used_r;
    if (cap_cnt_r != `STRAP_WAIT)
    begin
      cap_cnt_nxt = cap_cnt_r + 2'h1;
    end
    else
    begin
      cap_cnt_nxt = cap_cnt_r;
    end
    if (cap_cnt_r == `STRAP_WAIT - 2'h1)
    begin
      rc_slow_nxt   = sync_r[2];
      fast_used_nxt = sync_r[3];
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cap_cnt_r   <= 2'h0;
      rc_slow_r   <= 1'b0;
      fast_used_r <= 1'b0;
    end
    else
    begin
      cap_cnt_r   <= cap_cnt_nxt;
      rc_slow_r   <= rc_slow_nxt;
      fast_used_r <= fast_used_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, write and read data taken on the pready edge
  ctrl_s       ctrl_r;
  ctrl_s       ctrl_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic [31:0] stat_word;
  logic        access;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        src_fast;
  logic        lvl_r;
  logic [2:0]  settled;

  always_comb
  begin
    stat_word = 32'h0;
    stat_word[`STAT_SRC_FAST_BIT] = src_fast;
    stat_word[`STAT_REG_LVL_BIT]  = lvl_r;
    stat_word[`STAT_BOOST_OK_BIT] = settled[0];
    stat_word[`STAT_REG_OK_BIT]   = settled[1];
    stat_word[`STAT_FOSC_OK_BIT]  = settled[2];
    stat_word[`STAT_RC_SLOW_BIT]  = rc_slow_r;
    stat_word[`STAT_FOSC_USE_BIT] = fast_used_r;
  end

  always_comb
  begin
    access      = psel_in && penable_in;
    hit_ctrl    = paddr_in == `CTRL_OFFSET;
    hit_stat    = paddr_in == `STAT_OFFSET;
    ctrl_nxt    = ctrl_r;
    pready_nxt  = access && !pready_out;
    pslverr_nxt = 1'b0;
    prdata_nxt  = 32'h0;
    if (access && !pready_out)
    begin
      pslverr_nxt = !hit_ctrl && !hit_stat;
      if (!pwrite_in && hit_ctrl)
      begin
        prdata_nxt = {25'h0, ctrl_r};
      end
      else if (!pwrite_in && hit_stat)
      begin
        prdata_nxt = stat_word;
      end
    end
    // Every bit is stored as written; the ordering is left to software
    if (access && pready_out && pwrite_in && hit_ctrl && pstrb_in[0])
    begin
      ctrl_nxt = ctrl_s'(pwdata_in[`CTRL_WIDTH-1:0]);
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctrl_r      <= ctrl_s'(`CTRL_RESET);
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      pready_out  <= pready_nxt;
      pslverr_out <= pslverr_nxt;
      prdata_out  <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Effective regulator level; the RC option overrides the software bit
  logic lvl_nxt;

  always_comb
  begin
    if (rc_slow_r)
    begin
      lvl_nxt = fast_used_r;
    end
    else
    begin
      lvl_nxt = ctrl_r.osc_regulator_level;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      lvl_r <= 1'b0;
    end
    else
    begin
      lvl_r <= lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Settle timers: booster, regulator level, fast oscillator.
  // They only report; hardware does not hold back a write made too early.
  logic [2:0] arm;
  tmr_t       lim [3];

  always_comb
  begin
    arm[0] = ctrl_r.booster_enable;
    arm[1] = lvl_r;
    arm[2] = ctrl_r.fast_osc_enable;
    lim[0] = tmr_t'(BOOST_CYC - 1);
    lim[1] = tmr_t'(REG_CYC - 1);
    lim[2] = tmr_t'(FOSC_CYC - 1);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tmr
      tmr_t cnt_r;
      tmr_t cnt_nxt;
      logic done_r;
      logic done_nxt;

      always_comb
      begin
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (!arm[gi])
        begin
          cnt_nxt  = '0;
          done_nxt = 1'b0;
        end
        else if (!done_r)
        begin
          cnt_nxt  = cnt_r + tmr_t'(1);
          done_nxt = cnt_r == lim[gi];
        end
      end

      always_ff @(posedge ref_clk_in or posedge reset_in)
      begin
        if (reset_in)
        begin
          cnt_r  <= '0;
          done_r <= 1'b0;
        end
        else
        begin
          cnt_r  <= cnt_nxt;
          done_r <= done_nxt;
        end
      end

      assign settled[gi] = done_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // CPU clock selection; a stopped fast oscillator reads as low
  logic fast_lvl;

  always_comb
  begin
    fast_lvl = sync_r[1] && ctrl_r.fast_osc_enable;
  end

  glitch_free_clk_sel u_clk_sel
  (
    .ref_clk_in   (ref_clk_in),
    .reset_in     (reset_in),
    .slow_lvl_in  (sync_r[0]),
    .fast_lvl_in  (fast_lvl),
    .sel_fast_in  (ctrl_r.cpu_clock_select),
    .cpu_clk_out  (cpu_clk_out),
    .src_fast_out (src_fast)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Analog controls straight from the control flops; the regulator level comes from lvl_r
  assign fast_osc_enable_out          = ctrl_r.fast_osc_enable;
  assign osc_regulator_level_out      = lvl_r;
  assign booster_enable_out           = ctrl_r.booster_enable;
  assign osc_lowvolt_select_out       = ctrl_r.osc_lowvolt_select;
  assign converter_lowvolt_select_out = ctrl_r.converter_lowvolt_select;
  assign supply_detector_enable_out   = ctrl_r.supply_detector_enable;

endmodule : clock_power_mode_control

`default_nettype wire

// ---- bench/clkpwr_props.sv ----
/*
  Port checker of the clock and power mode control block.
  Assumes straps change only while reset is held.
*/
`timescale 1ns/100ps
`default_nettype none
module clkpwr_props
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Straps and controls
  input wire logic rc_slow_strap_in,
  input wire logic fast_used_strap_in,
  input wire logic cpu_clk_out,
  input wire logic fast_osc_enable_out,
  input wire logic osc_regulator_level_out,
  input wire logic booster_enable_out,
  input wire logic osc_lowvolt_select_out,
  input wire logic converter_lowvolt_select_out,
  input wire logic supply_detector_enable_out
);
  logic [2:0] age_r;
  logic [2:0] age_nxt;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Straps take a few edges to be captured, so wait for the count to saturate
  always_comb age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in) age_r <= 3'h0;
    else age_r <= age_nxt;
  clk_reset_a: assert property ($fell(reset_in) |-> !cpu_clk_out)
    else $error("cpu clock high at reset release");
  fosc_reset_a: assert property ($fell(reset_in) |-> !fast_osc_enable_out)
    else $error("fast enable high at reset release");
  level_reset_a: assert property ($fell(reset_in) |-> !osc_regulator_level_out)
    else $error("level high at reset release");
  boost_reset_a: assert property ($fell(reset_in) |-> !(booster_enable_out | osc_lowvolt_select_out |
    converter_lowvolt_select_out)) else $error("booster or select high at reset");
  svd_reset_a: assert property ($fell(reset_in) |-> !supply_detector_enable_out)
    else $error("detector on at reset release");
  level_fixed_a: assert property (age_r == 3'h7 && rc_slow_strap_in && fast_used_strap_in
    |-> osc_regulator_level_out) else $error("level not fixed high");
  level_low_a: assert property (age_r == 3'h7 && rc_slow_strap_in && !fast_used_strap_in
    |-> !osc_regulator_level_out) else $error("level not low");
  high_pulse_a: assert property ($rose(cpu_clk_out) |=> cpu_clk_out)
    else $error("short cpu clock high pulse");
  low_pulse_a: assert property ($fell(cpu_clk_out) |=> !cpu_clk_out)
    else $error("short cpu clock low pulse");
endmodule : clkpwr_props
bind clock_power_mode_control clkpwr_props u_props
(.ref_clk_in(ref_clk_in), .reset_in(reset_in), .rc_slow_strap_in(rc_slow_strap_in),
 .fast_used_strap_in(fast_used_strap_in), .cpu_clk_out(cpu_clk_out),
 .fast_osc_enable_out(fast_osc_enable_out), .osc_regulator_level_out(osc_regulator_level_out),
 .booster_enable_out(booster_enable_out), .osc_lowvolt_select_out(osc_lowvolt_select_out),
 .converter_lowvolt_select_out(converter_lowvolt_select_out),
 .supply_detector_enable_out(supply_detector_enable_out));
`default_nettype wire

// ---- bench/tb_clock_power_mode_control.sv ----
/*
  Self-checking bench of the clock and power mode control block.
  Assumes short settle counts on the instance and APB as master.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_clock_power_mode_control;
  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0]  pstrb_in = 4'h0;
  logic        slow_osc_in = 1'b0;
  logic        fast_osc_in = 1'b0;
  logic        rc_slow_strap_in = 1'b0;
  logic        fast_used_strap_in = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, cpu_clk_out, fast_osc_enable_out, osc_regulator_level_out;
  logic        booster_enable_out, osc_lowvolt_select_out, converter_lowvolt_select_out;
  logic        supply_detector_enable_out;
  logic [6:0]  pins;
  logic [31:0] cyc = 32'h0;
  logic [33:0] expq[$];
  logic [33:0] ev;
  int          fails = 0;
  int          comparisons = 0;
  assign pins = {supply_detector_enable_out, converter_lowvolt_select_out, osc_lowvolt_select_out,
                 booster_enable_out, osc_regulator_level_out, fast_osc_enable_out, 1'b0};
  clock_power_mode_control #(.BOOST_CYC(8), .REG_CYC(4), .FOSC_CYC(6)) dut
  (.ref_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
   .prdata_out, .pready_out, .pslverr_out, .slow_osc_in, .fast_osc_in, .rc_slow_strap_in,
   .fast_used_strap_in, .cpu_clk_out, .fast_osc_enable_out, .osc_regulator_level_out,
   .booster_enable_out, .osc_lowvolt_select_out, .converter_lowvolt_select_out,
   .supply_detector_enable_out);
  ////////////////////////////////////////////////////////////////////////////
  always #25 ref_clk_in = ~ref_clk_in;
  // Both oscillators are slow enough for the two-flop synchronisers
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 32'h1;
    fast_osc_in <= cyc[1];
    slow_osc_in <= cyc[4];
    if (cyc == 32'h1770)
    begin
      fails++;
      test_done();
    end
  end
  task automatic check(input string what, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check
  always @(posedge ref_clk_in)
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in && expq.size() > 0)
    begin
      ev = expq.pop_front();
      if (ev[33])
        check("read", ev[32:0], {pslverr_out, prdata_out});
    end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [33:0] e, output logic [31:0] q);
    @(posedge ref_clk_in);
    if (!w)
      expq.push_back(e);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    // Only the bench watchdog ends a wait for the answer
    do
    begin
      @(posedge ref_clk_in);
    end
    while (pready_out !== 1'b1);
    q = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [6:0] v);
    logic [31:0] q;
    apb(1'b1, a, {25'($urandom()), v}, 4'hf, 34'h0, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    logic [31:0] q;
    apb(1'b0, a, $urandom(), 4'hf, {1'b1, e}, q);
  endtask : rd
  task automatic poll(input int b, input logic v);
    logic [31:0] q;
    int          n;
    n = 0;
    do
    begin
      apb(1'b0, 12'h004, 32'h0, 4'hf, 34'h0, q);
      n++;
    end
    while (q[b] !== v && n < 30);
    check("status", {32'h0, v}, {32'h0, q[b]});
  endtask : poll
  task automatic pin(input logic [6:0] v);
    repeat (2) @(posedge ref_clk_in);
    check("pins", {26'h0, v & 7'h7e}, {26'h0, pins});
  endtask : pin
  // Rising edges of the cpu clock over n edges; whole source periods give an exact count
  task automatic rises(input int n, input int e);
    int   k;
    logic p;
    k = 0;
    p = cpu_clk_out;
    repeat (n)
    begin
      @(posedge ref_clk_in);
      if (cpu_clk_out && !p)
        k++;
      p = cpu_clk_out;
    end
    check("cpu clock rises", 33'(e), 33'(k));
  endtask : rises
  task automatic rst(input logic rc, input logic used);
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    rc_slow_strap_in <= rc;
    fast_used_strap_in <= used;
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 1'b0;
  endtask : rst
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] q;
    void'($urandom(32'h6dfe));
    rst(1'b0, 1'b0);
    pin(7'h00);
    rd(12'h000, 33'h0);
    rd(12'h004, 33'h0);
    rd(12'h008, 33'h100000000);
    wr(12'h004, 7'h7f);
    rd(12'h004, 33'h0);
    $display("test reset done");
    wr(12'h000, 7'h08);
    poll(2, 1'b1);
    wr(12'h000, 7'h18);
    wr(12'h000, 7'h38);
    pin(7'h38);
    wr(12'h000, 7'h08);
    pin(7'h08);
    wr(12'h000, 7'h00);
    pin(7'h00);
    $display("test low voltage done");
    wr(12'h000, 7'h04);
    poll(3, 1'b1);
    wr(12'h000, 7'h06);
    poll(4, 1'b1);
    wr(12'h000, 7'h07);
    poll(0, 1'b1);
    pin(7'h06);
    rises(16, 4);
    wr(12'h000, 7'h06);
    poll(0, 1'b0);
    wr(12'h000, 7'h04);
    wr(12'h000, 7'h00);
    rd(12'h004, 33'h0);
    $display("test clock switch done");
    wr(12'h000, 7'h40);
    apb(1'b1, 12'h000, 32'h0, 4'he, 34'h0, q);
    pin(7'h40);
    wr(12'h000, 7'h00);
    pin(7'h00);
    rises(32, 1);
    $display("test detector done");
    rst(1'b1, 1'b1);
    wr(12'h000, 7'h00);
    pin(7'h04);
    rd(12'h004, 33'h6a);
    rst(1'b1, 1'b0);
    wr(12'h000, 7'h04);
    pin(7'h00);
    rd(12'h004, 33'h20);
    $display("test straps done");
    test_done();
  end
endmodule : tb_clock_power_mode_control
`default_nettype wire
